// *** logic/codec_regs_pkg.sv ***
// Constants, bus carriers and state types for the codec control-register block.
// Assumes a 32-bit AXI4-Lite master and a single 20 MHz core clock.
package codec_regs_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [5:0] IDX_VOL_MIX    = 6'h03;
    localparam logic [5:0] IDX_VOL_FIRST  = 6'h04;
    localparam logic [5:0] IDX_VOL_SECOND = 6'h05;
    localparam logic [5:0] IDX_ADC_CTL    = 6'h06;
    localparam logic [5:0] IDX_MODE2      = 6'h07;
    localparam logic [5:0] IDX_ID         = 6'h08;
    localparam logic [5:0] IDX_NONE       = 6'h3f;

    // Field positions
    localparam int VOL_MUTE_BIT   = 7;
    localparam int MIX_LINK_BIT   = 6;
    localparam int MIX_SOFT_BIT   = 5;
    localparam int MIX_ZERO_BIT   = 4;
    localparam int ADC_DITHER_BIT = 5;
    localparam int ADC_FMT_BIT    = 4;
    localparam int ADC_MUTE_LO    = 2;
    localparam int ADC_HPF_LO     = 0;
    localparam int M2_LOOP_BIT    = 4;
    localparam int M2_LINK_BIT    = 3;
    localparam int M2_FREEZE_BIT  = 2;
    localparam int M2_CONTROL_PORT_ENABLE_BIT_BIT    = 1;
    localparam int M2_PDN_BIT     = 0;

    // Writable masks; the other bits are reserved and read zero
    localparam logic [7:0] MIX_MASK   = 8'h7f;
    localparam logic [7:0] ADC_MASK   = 8'h3f;
    localparam logic [7:0] MODE2_MASK = 8'h1f;

    // Reset values
    localparam logic [7:0] MIX_RST   = 8'h20;
    localparam logic [7:0] VOL_RST   = 8'h00;
    localparam logic [7:0] ADC_RST   = 8'h00;
    localparam logic [7:0] MODE2_RST = 8'h01;

    // Level in eighths of a dB; full mute lies below the -127 dB step
    localparam logic [10:0] LVL_FULL_MUTE   = 11'h400;
    localparam logic [9:0]  ZC_TIMEOUT_LAST = 10'h1ff;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        RAMP_IMMEDIATE = 2'b00,
        RAMP_ZERO      = 2'b01,
        RAMP_SOFT      = 2'b10,
        RAMP_SOFT_ZERO = 2'b11
    } ramp_mode_t;

    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic [2:0]  awprot;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic [2:0]  arprot;
        logic        rready;
    } axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_t;

endpackage : codec_regs_pkg

// *** logic/codec_volume_adc_mode_regs.sv ***
// Control registers of a stereo codec: DAC volume and mute ramps, ADC control,
// second mode register and identification, reached over AXI4-Lite.
// Assumes frameClk and zero_crossing_enable are synchronous to core_clk.
//
// What this block does
// - Mute bit silences its DAC channel, common-mode level kept.
// - Active-low mute indicator asserted while that channel's mute bit is set.
// - Mute transitions use the selected soft-ramp and zero-crossing modes.
// - Seven-bit attenuation, 1 dB per code, 0 down to -127 dB.
// - Attenuation changes follow the selected soft-ramp and zero-crossing mode.
// - Dither bit enables ADC dithering for 16-bit output.
// - ADC format bit: 0 left-justified (reset), 1 I2S.
// - Each ADC mute bit forces its channel output to mute.
// - High-pass disable freezes the offset estimate, still subtracted.
// - Loopback bit routes ADC data to the DAC path.
// - Link bit ANDs both mute conditions onto both indicators.
// - Freeze holds volume and ADC writes; clearing it applies them all at once.
// - Control-port enable resets to zero; host sets it for register control.
// - Power-down resets to one; host clears it before normal operation.
// - Register contents survive power-down unchanged.
// - Read-only identification: part code high nibble, revision low nibble.
// - Soft ramp steps 1/8 dB per frame, 1 dB per eight frames.
// - Zero-cross mode applies at a crossing or after 512 frames.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

module codec_volume_adc_mode_regs
    import codec_regs_pkg::*;
#(
    // Identification codes; values are arbitrary
    parameter logic [3:0] PART_CODE = 4'h5,
    parameter logic [3:0] REV_CODE  = 4'h3
) (
    // Clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      nrst,
    // Register bus
    input  wire codec_regs_pkg::axil_req_t axilReq,
    output var  codec_regs_pkg::axil_rsp_t axilRsp,
    // Audio timing
    input  wire logic                      frameClk,
    input  wire logic [1:0]                zero_crossing_enable,
    // DAC side
    output logic [1:0][10:0]               dacLevel,
    output logic [1:0]                     dacSilenced,
    output logic                           muteIndFirstN,
    output logic                           muteIndSecondN,
    // ADC side
    output logic                           adcDitherEn,
    output logic                           adcFormatI2s,
    output logic [1:0]                     adcMute,
    output logic [1:0]                     hpfFreeze,
    // Mode
    output logic                           loopbackEn,
    output logic                           controlPortEn,
    output logic                           powerDown
);
    import codec_regs_pkg::*;

    typedef struct packed {
        axil_rsp_t        rsp;
        logic             awGot;
        logic             wGot;
        logic [5:0]       wrIdx;
        logic [7:0]       wrData;
        logic             wrLane;
        logic [7:0]       mixSh;
        logic [7:0]       volFirstSh;
        logic [7:0]       volSecondSh;
        logic [7:0]       adcSh;
        logic [7:0]       mode2;
        logic [7:0]       mixAp;
        logic [7:0]       volFirstAp;
        logic [7:0]       volSecondAp;
        logic [7:0]       adcAp;
        logic [1:0][10:0] lvl;
        logic [1:0][9:0]  zcWait;
        logic             frameClkPrev;
        logic [1:0]       silenced;
        logic             indFirstN;
        logic             indSecondN;
    } state_t;

    state_t           s_r;
    state_t           s_nxt;
    logic             frameTick;
    ramp_mode_t       rampMode;
    logic [1:0]       chanMute;
    logic [1:0][10:0] target;
    logic [7:0]       volSecondUsed;
    logic             bothMuted;

    function automatic logic [7:0] regRead(input state_t st, input logic [5:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            IDX_VOL_MIX:    v = st.mixSh & MIX_MASK;
            IDX_VOL_FIRST:  v = st.volFirstSh;
            IDX_VOL_SECOND: v = st.volSecondSh;
            IDX_ADC_CTL:    v = st.adcSh & ADC_MASK;
            IDX_MODE2:      v = st.mode2 & MODE2_MASK;
            IDX_ID:         v = {PART_CODE, REV_CODE};
            default:        v = 8'h00;
        endcase
        return v;
    endfunction : regRead

    function automatic logic mapped(input logic [5:0] idx);
        return (idx >= IDX_VOL_MIX) && (idx <= IDX_ID);
    endfunction : mapped

    always_comb
    begin
        s_nxt     = s_r;
        frameTick = frameClk && !s_r.frameClkPrev;
        s_nxt.frameClkPrev = frameClk;

        // Write address and data are taken independently, in either order
        if (axilReq.awvalid && s_r.rsp.awready)
        begin
            s_nxt.awGot = 1'b1;
            s_nxt.wrIdx = (axilReq.awaddr[31:8] == 24'h000000) ? axilReq.awaddr[7:2] : IDX_NONE;
        end
        if (axilReq.wvalid && s_r.rsp.wready)
        begin
            s_nxt.wGot   = 1'b1;
            s_nxt.wrData = axilReq.wdata[7:0];
            s_nxt.wrLane = axilReq.wstrb[0];
        end
        if (s_r.rsp.bvalid && axilReq.bready)
        begin
            s_nxt.rsp.bvalid = 1'b0;
        end
        if (s_r.awGot && s_r.wGot && !s_r.rsp.bvalid)
        begin
            s_nxt.awGot      = 1'b0;
            s_nxt.wGot       = 1'b0;
            s_nxt.rsp.bvalid = 1'b1;
            s_nxt.rsp.bresp  = mapped(s_r.wrIdx) ? RESP_OKAY : RESP_DECERR;
            // Writes land in the shadow copies even while frozen or powered down
            if (s_r.wrLane)
            begin
                case (s_r.wrIdx)
                    IDX_VOL_MIX:    s_nxt.mixSh       = s_r.wrData & MIX_MASK;
                    IDX_VOL_FIRST:  s_nxt.volFirstSh  = s_r.wrData;
                    IDX_VOL_SECOND: s_nxt.volSecondSh = s_r.wrData;
                    IDX_ADC_CTL:    s_nxt.adcSh       = s_r.wrData & ADC_MASK;
                    IDX_MODE2:      s_nxt.mode2       = s_r.wrData & MODE2_MASK;
                    default:        s_nxt.mode2       = s_r.mode2;
                endcase
            end
        end
        s_nxt.rsp.awready = !s_nxt.awGot && !s_nxt.rsp.bvalid;
        s_nxt.rsp.wready  = !s_nxt.wGot && !s_nxt.rsp.bvalid;

        // Reads answer one cycle after the address is taken
        if (s_r.rsp.rvalid && axilReq.rready)
        begin
            s_nxt.rsp.rvalid  = 1'b0;
            s_nxt.rsp.arready = 1'b1;
        end
        if (axilReq.arvalid && s_r.rsp.arready)
        begin
            s_nxt.rsp.arready = 1'b0;
            s_nxt.rsp.rvalid  = 1'b1;
            if (axilReq.araddr[31:8] == 24'h000000 && mapped(axilReq.araddr[7:2]))
            begin
                s_nxt.rsp.rdata = {24'h000000, regRead(s_r, axilReq.araddr[7:2])};
                s_nxt.rsp.rresp = RESP_OKAY;
            end
            else
            begin
                s_nxt.rsp.rdata = 32'h00000000;
                s_nxt.rsp.rresp = RESP_DECERR;
            end
        end

        // Freeze gates the shadow-to-active copy; the mode register itself
        // acts at once, otherwise freeze could never be released
        if (!s_r.mode2[M2_FREEZE_BIT])
        begin
            s_nxt.mixAp       = s_r.mixSh;
            s_nxt.volFirstAp  = s_r.volFirstSh;
            s_nxt.volSecondAp = s_r.volSecondSh;
            s_nxt.adcAp       = s_r.adcSh;
        end

        rampMode      = ramp_mode_t'({s_r.mixAp[MIX_SOFT_BIT], s_r.mixAp[MIX_ZERO_BIT]});
        volSecondUsed = s_r.mixAp[MIX_LINK_BIT] ? s_r.volFirstAp : s_r.volSecondAp;
        chanMute      = {volSecondUsed[VOL_MUTE_BIT], s_r.volFirstAp[VOL_MUTE_BIT]};
        target[0]     = chanMute[0] ? LVL_FULL_MUTE : {1'b0, s_r.volFirstAp[6:0], 3'b000};
        target[1]     = chanMute[1] ? LVL_FULL_MUTE : {1'b0, volSecondUsed[6:0], 3'b000};

        // Ramps stand still in power-down so the level resumes where it was
        for (int ch = 0; ch < 2; ch++)
        begin
            if (!s_r.mode2[M2_PDN_BIT] && s_r.lvl[ch] != target[ch])
            begin
                case (rampMode)
                    RAMP_IMMEDIATE:
                    begin
                        s_nxt.lvl[ch]    = target[ch];
                        s_nxt.zcWait[ch] = 10'h000;
                    end
                    RAMP_SOFT:
                    begin
                        if (frameTick)
                        begin
                            s_nxt.lvl[ch] = (s_r.lvl[ch] < target[ch]) ? s_r.lvl[ch] + 11'h001
                                                                       : s_r.lvl[ch] - 11'h001;
                        end
                    end
                    RAMP_ZERO, RAMP_SOFT_ZERO:
                    begin
                        if (frameTick && (zero_crossing_enable[ch] || s_r.zcWait[ch] == ZC_TIMEOUT_LAST))
                        begin
                            s_nxt.zcWait[ch] = 10'h000;
                            if (rampMode == RAMP_ZERO)
                            begin
                                s_nxt.lvl[ch] = target[ch];
                            end
                            else
                            begin
                                s_nxt.lvl[ch] = (s_r.lvl[ch] < target[ch]) ? s_r.lvl[ch] + 11'h001
                                                                           : s_r.lvl[ch] - 11'h001;
                            end
                        end
                        else if (frameTick)
                        begin
                            s_nxt.zcWait[ch] = s_r.zcWait[ch] + 10'h001;
                        end
                    end
                    default:
                    begin
                        s_nxt.lvl[ch] = target[ch];
                    end
                endcase
            end
            else if (s_r.lvl[ch] == target[ch])
            begin
                s_nxt.zcWait[ch] = 10'h000;
            end
            // Full mute is the silent level; common mode stays on the pins
            s_nxt.silenced[ch] = (s_nxt.lvl[ch] == LVL_FULL_MUTE);
        end

        bothMuted = chanMute[0] && chanMute[1];
        if (s_r.mode2[M2_LINK_BIT])
        begin
            s_nxt.indFirstN  = !bothMuted;
            s_nxt.indSecondN = !bothMuted;
        end
        else
        begin
            s_nxt.indFirstN  = !chanMute[0];
            s_nxt.indSecondN = !chanMute[1];
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_r             <= '0;
            s_r.rsp.awready <= 1'b1;
            s_r.rsp.wready  <= 1'b1;
            s_r.rsp.arready <= 1'b1;
            s_r.mixSh       <= MIX_RST;
            s_r.mixAp       <= MIX_RST;
            s_r.volFirstSh  <= VOL_RST;
            s_r.volFirstAp  <= VOL_RST;
            s_r.volSecondSh <= VOL_RST;
            s_r.volSecondAp <= VOL_RST;
            s_r.adcSh       <= ADC_RST;
            s_r.adcAp       <= ADC_RST;
            s_r.mode2       <= MODE2_RST;
            s_r.indFirstN   <= 1'b1;
            s_r.indSecondN  <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign axilRsp        = s_r.rsp;
    assign dacLevel       = s_r.lvl;
    assign dacSilenced    = s_r.silenced;
    assign muteIndFirstN  = s_r.indFirstN;
    assign muteIndSecondN = s_r.indSecondN;
    assign adcDitherEn    = s_r.adcAp[ADC_DITHER_BIT];
    assign adcFormatI2s   = s_r.adcAp[ADC_FMT_BIT];
    assign adcMute        = s_r.adcAp[ADC_MUTE_LO +: 2];
    assign hpfFreeze      = s_r.adcAp[ADC_HPF_LO +: 2];
    assign loopbackEn     = s_r.mode2[M2_LOOP_BIT];
    assign controlPortEn  = s_r.mode2[M2_CONTROL_PORT_ENABLE_BIT_BIT];
    assign powerDown      = s_r.mode2[M2_PDN_BIT];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence wrBothTaken;
        s_r.awGot && s_r.wGot && !s_r.rsp.bvalid;
    endsequence

    sequence respRaised;
        ##1 axilRsp.bvalid;
    endsequence

    write_resp_timing_a: assert property (wrBothTaken |-> respRaised)
        else $error("write response not raised one cycle after both halves");

    resp_held_a: assert property (axilRsp.bvalid && !axilReq.bready |=> axilRsp.bvalid)
        else $error("write response dropped before acceptance");

    reserved_zero_a: assert property (axilRsp.rvalid |-> axilRsp.rdata[31:8] == 24'h000000)
        else $error("upper read data bits not zero");

    indicator_link_a: assert property (
        $past(s_r.mode2[M2_LINK_BIT]) |-> muteIndFirstN == muteIndSecondN)
        else $error("linked mute indicators differ");

    indicator_mute_a: assert property (
        !s_r.mode2[M2_LINK_BIT] && s_r.volFirstAp[VOL_MUTE_BIT] |=> !muteIndFirstN)
        else $error("first mute indicator not active while muted");

    freeze_hold_a: assert property (s_r.mode2[M2_FREEZE_BIT] |=> $stable(s_r.volFirstAp))
        else $error("volume applied while frozen");

    immediate_apply_a: assert property (
        rampMode == RAMP_IMMEDIATE && !powerDown && s_r.lvl[0] != target[0]
        |=> s_r.lvl[0] == $past(target[0]))
        else $error("immediate mode did not apply level");

    soft_step_a: assert property (
        rampMode == RAMP_SOFT && !frameTick |=> $stable(s_r.lvl[0]))
        else $error("soft ramp stepped without a frame edge");

    powerdown_hold_a: assert property (powerDown |=> $stable(s_r.lvl))
        else $error("level moved during power-down");

    zero_timeout_a: assert property (
        rampMode == RAMP_ZERO && frameTick && s_r.zcWait[0] == ZC_TIMEOUT_LAST && !powerDown
        && s_r.lvl[0] != target[0] |=> s_r.lvl[0] == $past(target[0]))
        else $error("zero-cross timeout did not force the change");

    // Silence flag and level register together, so they must agree every cycle
    mute_silence_a: assert property (
        dacSilenced[0] == (s_r.lvl[0] == LVL_FULL_MUTE))
        else $error("silence flag disagrees with full mute level");

    read_resp_timing_a: assert property (axilReq.arvalid && axilRsp.arready |=> axilRsp.rvalid)
        else $error("read data not valid one cycle after address taken");

    read_held_a: assert property (
        axilRsp.rvalid && !axilReq.rready |=> axilRsp.rvalid && $stable(axilRsp.rdata))
        else $error("read data changed before acceptance");

    soft_step_size_a: assert property (
        rampMode == RAMP_SOFT && frameTick && !powerDown && s_r.lvl[0] < target[0]
        |=> s_r.lvl[0] == $past(s_r.lvl[0]) + 11'h001)
        else $error("soft ramp step not one eighth dB");

    link_both_active_a: assert property (
        s_r.mode2[M2_LINK_BIT] && chanMute[0] && chanMute[1]
        |=> !muteIndFirstN && !muteIndSecondN)
        else $error("linked mute indicators not both active");

    adc_mute_apply_a: assert property (
        !s_r.mode2[M2_FREEZE_BIT] |=> adcMute == $past(s_r.adcSh[ADC_MUTE_LO +: 2]))
        else $error("ADC mute bits not applied while unfrozen");

endmodule : codec_volume_adc_mode_regs

`default_nettype wire

// *** testbench/codec_host_model.sv ***
// Host-side AXI4-Lite master that programs the codec control registers.
// Assumes one clock and that the bench calls wr and rd one at a time.
`timescale 1ns/1ns
`default_nettype none

module codec_host_model
    import codec_regs_pkg::*;
(
    // Clock
    input  wire logic                      core_clk,
    // Register bus
    output var  codec_regs_pkg::axil_req_t axilReq,
    input  wire codec_regs_pkg::axil_rsp_t axilRsp
);
    import codec_regs_pkg::*;

    initial axilReq = '0;

    // Address and data go out together; each is dropped once it is taken
    task automatic wr(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] resp);
        @(posedge core_clk);
        axilReq.awvalid <= 1'b1;
        axilReq.awaddr  <= {24'h0, idx, 2'b00};
        axilReq.wvalid  <= 1'b1;
        axilReq.wdata   <= {24'h0, d};
        axilReq.wstrb   <= 4'hf;
        axilReq.bready  <= 1'b1;
        forever
        begin
            @(posedge core_clk);
            if (axilReq.awvalid && axilRsp.awready)
                axilReq.awvalid <= 1'b0;
            if (axilReq.wvalid && axilRsp.wready)
                axilReq.wvalid <= 1'b0;
            if (axilRsp.bvalid)
            begin
                resp = axilRsp.bresp;
                axilReq.bready <= 1'b0;
                break;
            end
        end
    endtask : wr

    task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] resp);
        @(posedge core_clk);
        axilReq.arvalid <= 1'b1;
        axilReq.araddr  <= {24'h0, idx, 2'b00};
        axilReq.rready  <= 1'b1;
        forever
        begin
            @(posedge core_clk);
            if (axilReq.arvalid && axilRsp.arready)
                axilReq.arvalid <= 1'b0;
            if (axilRsp.rvalid)
            begin
                d    = axilRsp.rdata;
                resp = axilRsp.rresp;
                axilReq.rready <= 1'b0;
                break;
            end
        end
    endtask : rd

endmodule : codec_host_model
`default_nettype wire

// *** testbench/codec_volume_adc_mode_regs_tb.sv ***
// Self-checking bench for the codec control registers.
// Assumes the host model drives the bus; the bench drives frame ticks.
`timescale 1ns/1ns
`default_nettype none

module codec_volume_adc_mode_regs_tb;
    import codec_regs_pkg::*;

    // Identification codes; values are arbitrary
    localparam logic [3:0] PART = 4'ha;
    localparam logic [3:0] REV  = 4'h6;

    logic             core_clk = 1'b0;
    logic             nrst     = 1'b0;
    axil_req_t        axilReq;
    axil_rsp_t        axilRsp;
    logic             frameClk  = 1'b0;
    logic [1:0]       zero_crossing_enable = 2'b00;
    logic [1:0][10:0] dacLevel;
    logic [1:0]       dacSilenced;
    logic             muteIndFirstN;
    logic             muteIndSecondN;
    logic             adcDitherEn;
    logic             adcFormatI2s;
    logic [1:0]       adcMute;
    logic [1:0]       hpfFreeze;
    logic             loopbackEn;
    logic             controlPortEn;
    logic             powerDown;
    int               errors   = 0;
    int               compares = 0;
    logic [1:0]       resp;
    logic [31:0]      rdat;
    logic [6:0]       codes [5] = '{7'd20, 7'd40, 7'd60, 7'd90, 7'd127};

    always #25 core_clk = ~core_clk;

    codec_host_model codec_host_model_i (
        .core_clk (core_clk),
        .axilReq  (axilReq),
        .axilRsp  (axilRsp)
    );

    codec_volume_adc_mode_regs #(.PART_CODE(PART), .REV_CODE(REV)) codec_volume_adc_mode_regs_i (
        .core_clk       (core_clk),
        .nrst           (nrst),
        .axilReq        (axilReq),
        .axilRsp        (axilRsp),
        .frameClk       (frameClk),
        .zero_crossing_enable      (zero_crossing_enable),
        .dacLevel       (dacLevel),
        .dacSilenced    (dacSilenced),
        .muteIndFirstN  (muteIndFirstN),
        .muteIndSecondN (muteIndSecondN),
        .adcDitherEn    (adcDitherEn),
        .adcFormatI2s   (adcFormatI2s),
        .adcMute        (adcMute),
        .hpfFreeze      (hpfFreeze),
        .loopbackEn     (loopbackEn),
        .controlPortEn  (controlPortEn),
        .powerDown      (powerDown)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    // Leaves time for the active copy and the outputs to follow
    task automatic wreg(input logic [5:0] idx, input logic [7:0] d);
        codec_host_model_i.wr(idx, d, resp);
        chk(resp, RESP_OKAY);
        repeat (4) @(posedge core_clk);
    endtask : wreg

    task automatic rreg(input logic [5:0] idx, input logic [7:0] exp);
        codec_host_model_i.rd(idx, rdat, resp);
        chk(rdat, {24'h0, exp});
        chk(resp, RESP_OKAY);
    endtask : rreg

    // One frame tick every three cycles, zero-cross flags valid at the tick
    task automatic tick(input int n, input logic [1:0] zc);
        repeat (n)
        begin
            @(posedge core_clk);
            frameClk  <= 1'b1;
            zero_crossing_enable <= zc;
            @(posedge core_clk);
            frameClk  <= 1'b0;
            zero_crossing_enable <= 2'b00;
            @(posedge core_clk);
        end
        repeat (3) @(posedge core_clk);
    endtask : tick

    task automatic t_reset;
        chk({powerDown, controlPortEn, adcFormatI2s}, 3'b100);
        rreg(IDX_MODE2, 8'h01);
        rreg(IDX_ID, {PART, REV});
        wreg(IDX_ID, 8'h00);
        rreg(IDX_ID, {PART, REV});
        wreg(IDX_ADC_CTL, 8'h15);
        rreg(IDX_ADC_CTL, 8'h15);
        chk(adcFormatI2s, 1'b1);
        codec_host_model_i.wr(IDX_NONE, 8'hff, resp);
        chk(resp, RESP_DECERR);
        codec_host_model_i.rd(IDX_NONE, rdat, resp);
        chk(rdat, 32'h0);
        chk(resp, RESP_DECERR);
    endtask : t_reset

    task automatic t_mode;
        wreg(IDX_MODE2, 8'he0);
        rreg(IDX_MODE2, 8'h00);
        chk({powerDown, loopbackEn}, 2'b00);
        wreg(IDX_MODE2, 8'h12);
        chk({loopbackEn, controlPortEn}, 2'b11);
    endtask : t_mode

    task automatic t_adc;
        for (int i = 0; i < 6; i++)
        begin
            wreg(IDX_ADC_CTL, 8'h01 << i);
            chk({adcDitherEn, adcFormatI2s, adcMute, hpfFreeze}, 6'h01 << i);
        end
        // Set, write, clear: the host side of a grouped update
        wreg(IDX_MODE2, 8'h16);
        wreg(IDX_ADC_CTL, 8'h2a);
        chk({adcDitherEn, adcFormatI2s, adcMute, hpfFreeze}, 6'h20);
        rreg(IDX_ADC_CTL, 8'h2a);
        wreg(IDX_MODE2, 8'h12);
        chk({adcDitherEn, adcFormatI2s, adcMute, hpfFreeze}, 6'h2a);
    endtask : t_adc

    task automatic t_volume;
        wreg(IDX_VOL_MIX, 8'h00);
        foreach (codes[i])
        begin
            wreg(IDX_VOL_FIRST, {1'b0, codes[i]});
            chk(dacLevel[0], {codes[i], 3'b000});
        end
        wreg(IDX_VOL_FIRST, 8'h80);
        chk({dacSilenced, dacLevel[0]}, {2'b01, 11'h400});
        chk({muteIndSecondN, muteIndFirstN}, 2'b10);
        wreg(IDX_MODE2, 8'h1a);
        chk({muteIndSecondN, muteIndFirstN}, 2'b11);
        wreg(IDX_VOL_SECOND, 8'h80);
        chk({muteIndSecondN, muteIndFirstN, dacSilenced}, 4'b0011);
        wreg(IDX_VOL_FIRST, 8'h00);
        wreg(IDX_VOL_SECOND, 8'h00);
        wreg(IDX_MODE2, 8'h12);
        chk({muteIndSecondN, muteIndFirstN}, 2'b11);
    endtask : t_volume

    task automatic t_ramps;
        wreg(IDX_VOL_MIX, 8'h20);
        wreg(IDX_VOL_FIRST, 8'h01);
        chk(dacLevel[0], 11'd0);
        tick(3, 2'b00);
        chk(dacLevel[0], 11'd3);
        tick(7, 2'b00);
        chk(dacLevel[0], 11'd8);
        wreg(IDX_VOL_FIRST, 8'h81);
        tick(1, 2'b00);
        chk(dacLevel[0], 11'd9);
        wreg(IDX_VOL_MIX, 8'h10);
        wreg(IDX_VOL_SECOND, 8'h02);
        tick(511, 2'b00);
        chk(dacLevel[1], 11'd0);
        tick(513, 2'b00);
        chk(dacLevel[1], 11'd16);
        wreg(IDX_VOL_SECOND, 8'h04);
        tick(1, 2'b10);
        chk(dacLevel[1], 11'd32);
        // Soft ramp with zero cross: one eighth-dB step at a crossing, none on the frames before it
        wreg(IDX_VOL_MIX, 8'h30);
        wreg(IDX_VOL_SECOND, 8'h05);
        tick(2, 2'b00);
        chk(dacLevel[1], 11'd32);
        tick(1, 2'b10);
        chk(dacLevel[1], 11'd33);
        wreg(IDX_MODE2, 8'h13);
        tick(1, 2'b10);
        chk({powerDown, dacLevel[1]}, {1'b1, 11'd33});
        rreg(IDX_VOL_SECOND, 8'h05);
        wreg(IDX_MODE2, 8'h12);
        // Second channel follows the first volume byte, which is muted
        wreg(IDX_VOL_MIX, 8'h40);
        chk({muteIndSecondN, dacSilenced, dacLevel[1]}, {1'b0, 2'b11, 11'h400});
    endtask : t_ramps

    task automatic close_out;
        $display("Comparisons %0d, errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    initial
    begin
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset();
        t_mode();
        t_adc();
        t_volume();
        t_ramps();
        close_out();
    end

    // The whole run needs about 3500 cycles
    initial
    begin
        repeat (20000) @(posedge core_clk);
        errors++;
        close_out();
    end

endmodule : codec_volume_adc_mode_regs_tb
`default_nettype wire
